// ==== core/gsb_core.sv ====
`timescale 1ns/1ns
// ----------------------------------------
// status byte and service request core
// ----------------------------------------
module gsb_core import gsb_pkg::*; (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic cmd_valid,
	input wire gsb_cmd_t cmd_code,
	input wire logic [7:0] cmd_data,
	input wire logic [WIDE_W-1:0] ques_cond,
	input wire logic [WIDE_W-1:0] ques_en,
	input wire logic [7:0] esr_cond,
	input wire logic [7:0] esr_en,
	input wire logic [WIDE_W-1:0] oper_cond,
	input wire logic [WIDE_W-1:0] oper_en,
	input wire logic msg_avail,
	output logic rsp_valid_ff,
	output logic [7:0] rsp_data_ff,
	output logic [7:0] stb_ff,
	output logic srq_ff,
	output logic dflt_ff
);
	// ----------------------------------------
	// command decode
	// ----------------------------------------
	logic do_rst; // reset command taken
	logic do_sre_set; // mask write taken
	logic do_sre_qry; // mask query taken
	logic do_stb_qry; // status byte query taken
	logic [7:0] sre_mask; // current enable mask

	// commands are accepted whatever the instrument is doing
	// every code is decoded on its own; only one code can stand per cycle,
	// so at most one of the strobes below is high at any edge
	// the reset command clears the mask and pulses dflt_ff; source registers live outside
	assign do_rst = cmd_valid && (cmd_code == GSB_CMD_RST);
	assign do_sre_set = cmd_valid && (cmd_code == GSB_CMD_SRE_SET);
	assign do_sre_qry = cmd_valid && (cmd_code == GSB_CMD_SRE_QRY);
	assign do_stb_qry = cmd_valid && (cmd_code == GSB_CMD_STB_QRY);

	// mask storage
	gsb_mask_reg u_mask (
		.mclk(mclk),
		.rstn(rstn),
		.wr_en(do_sre_set),
		.wr_data(cmd_data),
		.clr(do_rst),
		.mask_ff(sre_mask)
	);

	// ----------------------------------------
	// status byte and service request
	// ----------------------------------------
	logic [7:0] nxt_stb; // next status byte
	logic nxt_srq; // next service request level
	logic nxt_dflt; // next defaults-restored pulse

	// summary bits are ORs of enabled source bits; bit 6 follows the request
	// the request is a level: it stays up as long as an enabled live bit is
	// true, and drops one cycle after the last such bit or its mask goes away
	// mask bit 6 is ignored so the summary can never hold itself up
	always_comb begin
		nxt_stb = STB_RESET;
		nxt_stb[QUES_BIT] = |(ques_cond & ques_en);
		nxt_stb[MAV_BIT] = msg_avail;
		nxt_stb[ESB_BIT] = |(esr_cond & esr_en);
		nxt_stb[OPER_BIT] = |(oper_cond & oper_en);
		// only masked-in live bits may request service
		nxt_srq = |(nxt_stb & sre_mask & SRQ_SRC_MASK);
		nxt_stb[RQS_BIT] = nxt_srq;
		nxt_dflt = do_rst;
	end

	// register status outputs
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			stb_ff <= STB_RESET;
			srq_ff <= 1'b0;
			dflt_ff <= 1'b0;
		end else begin
			stb_ff <= nxt_stb;
			srq_ff <= nxt_srq;
			dflt_ff <= nxt_dflt;
		end
	end

	// ----------------------------------------
	// query answers
	// ----------------------------------------
	logic nxt_rsp_valid; // next answer strobe
	logic [7:0] nxt_rsp_data; // next answer value

	// one answer per query, one cycle after the command
	// the answer value is held between strobes so a slow reader still sees it
	// a status byte query returns the byte as registered before the taking edge
	always_comb begin
		nxt_rsp_valid = 1'b0;
		nxt_rsp_data = rsp_data_ff;
		if (do_sre_qry) begin
			nxt_rsp_valid = 1'b1;
			nxt_rsp_data = sre_mask;
		end else if (do_stb_qry) begin
			nxt_rsp_valid = 1'b1;
			nxt_rsp_data = stb_ff;
		end
	end

	// register answers
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			rsp_valid_ff <= 1'b0;
			rsp_data_ff <= 8'h00;
		end else begin
			rsp_valid_ff <= nxt_rsp_valid;
			rsp_data_ff <= nxt_rsp_data;
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);

	a_rst_mask_clear: assert property (do_rst |=> (sre_mask == SRE_RESET) && dflt_ff)
		else $error("mask not cleared by reset command");
	a_sre_write_store: assert property (do_sre_set && !do_rst |=> sre_mask == $past(cmd_data))
		else $error("mask write not stored");
	a_sre_query_ans: assert property (do_sre_qry |=> rsp_valid_ff && rsp_data_ff == $past(sre_mask))
		else $error("mask query answer wrong");
	a_srq_raise_now: assert property (|(nxt_stb & sre_mask & SRQ_SRC_MASK) |=> srq_ff)
		else $error("service request not raised");
	a_srq_masked_off: assert property (srq_ff |-> |(stb_ff & $past(sre_mask) & SRQ_SRC_MASK))
		else $error("service request without enabled bit");
	a_stb_query_ans: assert property (do_stb_qry |=> rsp_valid_ff && rsp_data_ff == $past(stb_ff))
		else $error("status byte answer wrong");
	a_ques_summary: assert property (stb_ff[QUES_BIT] == |($past(ques_cond) & $past(ques_en)))
		else $error("questionable summary wrong");
	a_mav_follows: assert property ($rose(msg_avail) |=> stb_ff[MAV_BIT] ##1 (stb_ff[MAV_BIT] == $past(msg_avail)))
		else $error("message available bit wrong");
	a_esb_summary: assert property (stb_ff[ESB_BIT] == |($past(esr_cond) & $past(esr_en)))
		else $error("event summary wrong");
	a_rqs_tracks: assert property (stb_ff[RQS_BIT] == srq_ff)
		else $error("request summary bit differs from request");
	a_oper_summary: assert property (stb_ff[OPER_BIT] == |($past(oper_cond) & $past(oper_en)))
		else $error("operation summary wrong");
	a_low_bits_zero: assert property (stb_ff[2:0] == 3'h0 && !(rsp_valid_ff && rsp_data_ff[2:0] != 3'h0 && $past(do_stb_qry)))
		else $error("unused status bits nonzero");
	a_answer_single: assert property (rsp_valid_ff |-> $past(do_sre_qry || do_stb_qry))
		else $error("answer without query");

	// ----------------------------------------
	// command side effects
	// ----------------------------------------
	// defaults-restored pulse follows the reset command by exactly one cycle
	a_dflt_follows: assert property (dflt_ff == $past(do_rst))
		else $error("defaults pulse does not follow reset command");
	// a reset command gives no answer strobe
	a_rst_no_answer: assert property (do_rst |=> !rsp_valid_ff)
		else $error("answer after reset command");
	// a mask write gives no answer strobe
	a_set_no_answer: assert property (do_sre_set |=> !rsp_valid_ff)
		else $error("answer after mask write");
	// the mask only moves on a write or a reset command
	a_mask_hold: assert property (!do_rst && !do_sre_set |=> sre_mask == $past(sre_mask))
		else $error("mask changed without command");
	// the answer value stands between strobes
	a_rsp_hold: assert property (!rsp_valid_ff |-> rsp_data_ff == $past(rsp_data_ff))
		else $error("answer value moved without strobe");
	// status byte answers never carry the unused low bits
	a_stb_ans_low: assert property (rsp_valid_ff && $past(do_stb_qry) |-> rsp_data_ff[2:0] == 3'h0)
		else $error("status answer low bits nonzero");

	// ----------------------------------------
	// message available and service request level
	// ----------------------------------------
	// message available bit follows its source with one cycle of latency
	a_mav_level: assert property (stb_ff[MAV_BIT] == $past(msg_avail))
		else $error("message available level wrong");
	// an all-clear mask keeps the request line low
	a_srq_mask_zero: assert property (sre_mask == 8'h00 |=> !srq_ff)
		else $error("service request with empty mask");
	// request level equals enabled live bits of the previous cycle
	a_srq_level: assert property (srq_ff == |($past(nxt_stb) & $past(sre_mask) & SRQ_SRC_MASK))
		else $error("service request level wrong");
	// the request summary never holds itself up without a live bit
	a_rqs_no_self: assert property (srq_ff |-> |(stb_ff & SRQ_SRC_MASK))
		else $error("request summary without live bit");

	c_srq_raised: cover property (!srq_ff ##1 srq_ff);
	c_rst_while_srq: cover property (srq_ff && do_rst ##1 !srq_ff [*2]);
	c_stb_read: cover property (do_stb_qry ##1 rsp_valid_ff && rsp_data_ff[RQS_BIT]);
	c_mask_roundtrip: cover property (do_sre_set ##1 do_sre_qry ##1 rsp_valid_ff);
	c_mav_srq: cover property (msg_avail && sre_mask[MAV_BIT] ##1 srq_ff);
endmodule // gsb_core

// ==== core/gsb_mask_reg.sv ====
`timescale 1ns/1ns
// ----------------------------------------
// service request enable mask holder
// ----------------------------------------
module gsb_mask_reg import gsb_pkg::*; (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic wr_en,
	input wire logic [7:0] wr_data,
	input wire logic clr,
	output logic [7:0] mask_ff
);
	logic [7:0] nxt_mask; // next mask value

	// clear beats write so a reset command always lands on defaults
	always_comb begin
		nxt_mask = mask_ff;
		if (clr) begin
			nxt_mask = SRE_RESET;
		end else if (wr_en) begin
			nxt_mask = wr_data;
		end
	end

	// register the mask
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			mask_ff <= SRE_RESET;
		end else begin
			mask_ff <= nxt_mask;
		end
	end
endmodule // gsb_mask_reg

// ==== core/gsb_pkg.sv ====
// What this block does
// - reset command restores defaults in any mode
// - enable mask writable, readable, values 0..255
// - raise service request on enabled true bit
// - no service request from masked-off bits
// - summary bit is OR of enabled sources
// - status byte query returns current byte
// - bit 3 summarises questionable conditions
// - bit 4 set while output message waits
// - bit 5 summarises standard event conditions
// - bit 6 reports request service summary
// - bit 7 summarises operation conditions
package gsb_pkg;
	// ----------------------------------------
	// widths
	// ----------------------------------------
	localparam int BYTE_W = 8; // status byte and mask width
	localparam int WIDE_W = 16; // questionable and operation register width
	// ----------------------------------------
	// status byte bit positions
	// ----------------------------------------
	localparam int QUES_BIT = 3; // questionable summary
	localparam int MAV_BIT = 4; // message available
	localparam int ESB_BIT = 5; // event status summary
	localparam int RQS_BIT = 6; // request service summary
	localparam int OPER_BIT = 7; // operation summary
	// bits that may request service (all live bits except the summary itself)
	localparam logic [7:0] SRQ_SRC_MASK = 8'hB8;
	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [7:0] SRE_RESET = 8'h00; // mask after power-up or reset command
	localparam logic [7:0] STB_RESET = 8'h00; // status byte after reset
	// ----------------------------------------
	// commands from the remote interface
	// ----------------------------------------
	typedef enum logic [1:0] {
		GSB_CMD_RST,
		GSB_CMD_SRE_SET,
		GSB_CMD_SRE_QRY,
		GSB_CMD_STB_QRY
	} gsb_cmd_t;
endpackage

// ==== tb/gsb_ctrl_model.sv ====
`timescale 1ns/1ns
// ----------------------------------------
// bus controller issuing common commands
// ----------------------------------------
module gsb_ctrl_model import gsb_pkg::*; (
	input wire logic mclk,
	output logic cmd_valid,
	output gsb_cmd_t cmd_code,
	output logic [7:0] cmd_data,
	input wire logic rsp_valid_ff,
	input wire logic [7:0] rsp_data_ff
);
	// idle until the bench asks for a command
	initial begin
		cmd_valid = 1'b0;
		cmd_code = GSB_CMD_RST;
		cmd_data = 8'h00;
	end
	// one command per call, after an optional idle gap; answer taken one edge later
	task automatic issue(input gsb_cmd_t c, input logic [7:0] d, input int gap,
		output logic got, output logic [7:0] val);
		repeat (gap) @(posedge mclk);
		@(posedge mclk);
		#1;
		cmd_valid = 1'b1;
		cmd_code = c;
		cmd_data = d;
		@(posedge mclk);
		#1;
		cmd_valid = 1'b0;
		// released data no longer shows the old value
		cmd_data = ~d;
		got = rsp_valid_ff;
		val = rsp_data_ff;
	endtask
endmodule // gsb_ctrl_model

// ==== tb/gsb_status_byte_srq_tb.sv ====
`timescale 1ns/1ns
module gsb_status_byte_srq_tb import gsb_pkg::*;;
	logic mclk, rstn, cmd_valid, msg_avail, rsp_valid_ff, srq_ff, dflt_ff, got;
	gsb_cmd_t cmd_code;
	logic [7:0] cmd_data, esr_cond, esr_en, rsp_data_ff, stb_ff, val, ex;
	logic [15:0] ques_cond, ques_en, oper_cond, oper_en;
	int bad_count = 0;
	int check_count = 0;
	// ----------------------------------------
	// instances
	// ----------------------------------------
	gsb_core i_gsb_core (.mclk(mclk), .rstn(rstn), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
		.cmd_data(cmd_data), .ques_cond(ques_cond), .ques_en(ques_en), .esr_cond(esr_cond),
		.esr_en(esr_en), .oper_cond(oper_cond), .oper_en(oper_en), .msg_avail(msg_avail),
		.rsp_valid_ff(rsp_valid_ff), .rsp_data_ff(rsp_data_ff), .stb_ff(stb_ff),
		.srq_ff(srq_ff), .dflt_ff(dflt_ff));
	gsb_ctrl_model i_gsb_ctrl_model (.mclk(mclk), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
		.cmd_data(cmd_data), .rsp_valid_ff(rsp_valid_ff), .rsp_data_ff(rsp_data_ff));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		check_count++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %0t got %h expected %h", $time, g, e);
		end
	endtask
	// expected byte from the current sources and a mask
	function automatic logic [7:0] exp_stb(input logic [7:0] m);
		logic [7:0] b;
		b = {|(oper_cond & oper_en), 1'b0, |(esr_cond & esr_en), msg_avail,
			|(ques_cond & ques_en), 3'h0};
		b[6] = |(b & m & SRQ_SRC_MASK);
		return b;
	endfunction
	// program mask, apply sources, then judge byte and request line
	task automatic case_src(input logic [7:0] m, input logic [15:0] q, qe, o, oe,
		input logic [7:0] e, ee, input logic ma);
		i_gsb_ctrl_model.issue(GSB_CMD_SRE_SET, m, 0, got, val);
		chk({7'h00, got}, 8'h00);
		ques_cond = q;
		ques_en = qe;
		oper_cond = o;
		oper_en = oe;
		esr_cond = e;
		esr_en = ee;
		msg_avail = ma;
		@(posedge mclk);
		#1;
		ex = exp_stb(m);
		chk(stb_ff, ex);
		chk({7'h00, srq_ff}, {7'h00, ex[6]});
		i_gsb_ctrl_model.issue(GSB_CMD_STB_QRY, 8'h00, 1, got, val);
		chk({got, val}, {1'b1, ex});
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_mask_rw();
		logic [7:0] v [4] = '{8'hA8, 8'hFF, 8'h00, 8'h5A};
		foreach (v[i]) begin
			i_gsb_ctrl_model.issue(GSB_CMD_SRE_SET, v[i], i, got, val);
			i_gsb_ctrl_model.issue(GSB_CMD_SRE_QRY, 8'h00, 0, got, val);
			chk({got, val}, {1'b1, v[i]});
		end
	endtask
	task automatic t_summaries();
		case_src(8'h08, 16'h0001, 16'h0000, 0, 0, 0, 0, 0);
		case_src(8'h08, 16'h0100, 16'h0100, 0, 0, 0, 0, 0);
		case_src(8'h10, 0, 0, 0, 0, 0, 0, 1);
		case_src(8'h20, 0, 0, 0, 0, 8'h04, 8'h04, 0);
		case_src(8'h80, 0, 0, 16'h8000, 16'h8000, 0, 0, 0);
		case_src(8'h47, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 8'hFF, 8'hFF, 1);
		case_src(8'h08, 0, 0, 16'h8000, 16'h8000, 8'h01, 8'h01, 1);
		case_src(8'hFF, 16'h0002, 16'h0002, 0, 0, 0, 0, 0);
		chk(stb_ff & 8'h07, 8'h00);
	endtask
	task automatic t_reset_cmd();
		i_gsb_ctrl_model.issue(GSB_CMD_RST, 8'h00, 0, got, val);
		chk({7'h00, dflt_ff}, 8'h01);
		i_gsb_ctrl_model.issue(GSB_CMD_SRE_QRY, 8'h00, 0, got, val);
		chk({got, val}, {1'b1, SRE_RESET});
		chk({7'h00, srq_ff, dflt_ff}, 8'h00);
	endtask
	// ----------------------------------------
	// clock, watchdog, verdict
	// ----------------------------------------
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	initial begin
		repeat (3000) @(posedge mclk);
		bad_count++;
		complete_run();
	end
	task automatic complete_run();
		$display("mismatches %0d checks %0d", bad_count, check_count);
		if (bad_count == 0 && check_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		{rstn, ques_cond, ques_en, oper_cond, oper_en, esr_cond, esr_en, msg_avail} = '0;
		repeat (3) @(posedge mclk);
		#1;
		rstn = 1'b1;
		chk(stb_ff, STB_RESET);
		t_mask_rw();
		t_summaries();
		t_reset_cmd();
		complete_run();
	end
endmodule // gsb_status_byte_srq_tb
